// ===== shared/eld_pkg.sv
/*
  Constants, register map and carrier types of the E1 loss and alarm detector.
  Assumes a single 40 MHz system clock and a 32-bit plain register port.
*/
`default_nettype none
package eld_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [12:0] CTRL_RESET  = 13'h0000;
  localparam int          ST_LOS_BIT  = 0;
  localparam int          ST_AIS_BIT  = 1;
  localparam int          ST_EVT_BIT  = 2;

  // ---------------------------------------------------------------
  // Detection counts, in bit periods
  // ---------------------------------------------------------------
  localparam int N_SHORT     = 32;
  localparam int N_LONG      = 2048;
  localparam int M_CLEAR     = 32;
  localparam int MIN_MARKS   = 4;
  localparam int MAX_ZRUN    = 16;
  localparam int AIS_BLOCK   = 512;
  localparam int AIS_ZEROS   = 3;

  // Control register, bit 12 downward
  typedef struct packed {
    logic [4:0] level;
    logic       irq_mask;
    logic       monitor_gain;
    logic       rx_power_down;
    logic       cdr_enable;
    logic       eq_enable;
    logic       line_alarm_fill_enable;
    logic       system_alarm_fill_enable;
    logic       detect_criteria_select;
  } eld_ctrl_t;

  // Pins from the receive front end
  typedef struct packed {
    logic hw_mode;
    logic above_p;
    logic below_q;
    logic mclk;
    logic rclk;
    logic rail_neg;
    logic rail_pos;
  } eld_pins_t;

  localparam int PIN_W = $bits(eld_pins_t);
endpackage
`default_nettype wire

// ===== logic/eld_detect.sv
/*
  E1 receive loss-of-signal and alarm-indication detector with all-ones fill.
  Assumes sliced rails, recovered and master clocks and level comparator
  flags arrive as asynchronous pins; software uses the plain register port.
*/
// Added by the designer: the register offsets and strobed register access.
// Function
// - Declare loss after N intervals below Q
// - Loss drives pin high, unmasked interrupt
// - Clear after 32 good intervals from pulse
// - Loss clear drives pin low
// - Equalizer off uses fixed threshold code
// - Equalizer on takes five-bit level field
// - Pin control forbids equalizer and levels
// - One bit selects loss and alarm criteria
// - Criteria select resets to zero
// - Fill off passes rails and recovered clock
// - Fill on outputs ones, master clock
// - Line fill sends ones on master clock
// - Loss detection works in any loopback
// - No loss indication under monitor gain
// - Alarm detect only with clock recovery
// - Criteria 0 needs two agreeing blocks
// - Criteria 1 needs one block
// - Power down forces outputs low; los_irq, eq_active, threshold_code and rd_data are not forced
`timescale 1ns/1ps
`default_nettype none
module eld_detect
  import eld_pkg::*;
#(
  parameter int N_S   = eld_pkg::N_SHORT,
  parameter int N_L   = eld_pkg::N_LONG,
  parameter int BLOCK = eld_pkg::AIS_BLOCK
)(
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire eld_pkg::eld_pins_t pins,
  input  wire logic [7:0]       addr,
  input  wire logic [31:0]      wr_data,
  input  wire logic             wr_stb,
  input  wire logic             rd_stb,
  output logic [31:0]           rd_data,
  output logic                  los_pin,
  output logic                  los_irq,
  output logic [1:0]            receive_rail_pair,
  output logic                  rx_clk_out,
  output logic [1:0]            transmit_line_pair,
  output logic                  line_fill_active,
  output logic                  eq_active,
  output logic [4:0]            threshold_code
);
  import eld_pkg::*;

  localparam int CW = $clog2(N_L + 1);
  localparam int BW = $clog2(BLOCK + 1);

  if (N_S < 2 || N_L <= N_S || N_L < M_CLEAR || BLOCK < 8)
    $error("eld_detect: bad window parameters");

  typedef enum {ST_OK, ST_WAIT, ST_CHECK} eld_state_t;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [PIN_W-1:0] sync1_reg;
  logic [PIN_W-1:0] sync2_reg;
  eld_pins_t        s;
  logic             rclk_d_reg;
  logic             mclk_d_reg;
  wire              tick;
  wire              mtick;
  wire              mark;

  always_ff @(posedge sys_clk)
  begin
    sync1_reg  <= reset ? '0 : pins;
    sync2_reg  <= reset ? '0 : sync1_reg;
    rclk_d_reg <= reset ? 1'b0 : s.rclk;
    mclk_d_reg <= reset ? 1'b0 : s.mclk;
  end

  assign s     = sync2_reg;
  assign tick  = s.rclk & ~rclk_d_reg;
  assign mtick = s.mclk & ~mclk_d_reg;
  assign mark  = s.rail_pos | s.rail_neg;

  // ---------------------------------------------------------------
  // Control and status registers
  // ---------------------------------------------------------------
  eld_ctrl_t   ctrl_reg;
  logic        evt_reg;
  logic        los_reg;
  logic        ais_reg;
  logic [31:0] rd_data_reg;
  wire         sel_ctrl;
  wire         sel_stat;
  wire         rx_pd;
  wire         los_active;
  wire         los_rise;
  wire [31:0]  rd_mux;

  assign sel_ctrl = addr == ADDR_CTRL;
  assign sel_stat = addr == ADDR_STATUS;
  assign rx_pd    = ctrl_reg.rx_power_down;
  // loopback never gates; monitor gain, power down
  assign los_active = ~ctrl_reg.monitor_gain & ~rx_pd;
  assign rd_mux = sel_ctrl ? {19'h0, ctrl_reg}
                : sel_stat ? {29'h0, evt_reg, ais_reg, los_reg}
                : 32'h0;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ctrl_reg    <= CTRL_RESET;
      rd_data_reg <= 32'h0;
      evt_reg     <= 1'b0;
    end
    else
    begin
      if (wr_stb && sel_ctrl)
        ctrl_reg <= wr_data[12:0];
      rd_data_reg <= rd_stb ? rd_mux : 32'h0;
      // event sticky, set wins over clear
      if (los_rise)
        evt_reg <= 1'b1;
      else if (wr_stb && sel_stat && wr_data[ST_EVT_BIT])
        evt_reg <= 1'b0;
    end
  end

  assign rd_data = rd_data_reg;
  assign los_irq = evt_reg & ~ctrl_reg.irq_mask;

  // ---------------------------------------------------------------
  // Threshold selection
  // ---------------------------------------------------------------
  // pin control keeps the equalizer off
  assign eq_active = ctrl_reg.eq_enable & ~s.hw_mode;
  // code zero is the fixed threshold; level field
  assign threshold_code = eq_active ? ctrl_reg.level : 5'h00;

  // ---------------------------------------------------------------
  // Loss of signal
  // ---------------------------------------------------------------
  eld_state_t state_reg;
  eld_state_t state_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic [5:0]    ones_reg;
  logic [5:0]    ones_next;
  logic [4:0]    zrun_reg;
  logic [4:0]    zrun_next;
  logic          los_next;
  wire  [CW-1:0] n_lim;

  assign n_lim = ctrl_reg.detect_criteria_select ? CW'(N_L) : CW'(N_S);

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    ones_next  = ones_reg;
    zrun_next  = zrun_reg;
    los_next   = los_reg;
    if (!los_active)
    begin
      state_next = ST_OK;
      cnt_next   = '0;
      los_next   = 1'b0;
    end
    else if (tick)
    begin
      case (state_reg)
        ST_OK:
        begin
          if (s.below_q && cnt_reg == n_lim - 1'b1)
          begin
            los_next   = 1'b1;
            state_next = ST_WAIT;
            cnt_next   = '0;
          end
          else
            cnt_next = s.below_q ? cnt_reg + 1'b1 : '0;
        end
        ST_WAIT:
        begin
          // window opens on a received pulse
          if (mark && s.above_p)
          begin
            state_next = ST_CHECK;
            cnt_next   = CW'(1);
            ones_next  = 6'd1;
            zrun_next  = 5'd0;
          end
        end
        default:
        begin
          zrun_next = mark ? 5'd0 : zrun_reg + 1'b1;
          ones_next = ones_reg + {5'd0, mark};
          cnt_next  = cnt_reg + 1'b1;
          // level, zero run and density checks
          if (!s.above_p || zrun_next >= 5'(MAX_ZRUN))
            state_next = ST_WAIT;
          else if (cnt_reg == CW'(M_CLEAR - 1))
          begin
            state_next = ones_next >= 6'(MIN_MARKS) ? ST_OK : ST_WAIT;
            los_next   = ones_next < 6'(MIN_MARKS);
            cnt_next   = '0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_reg <= ST_OK;
      cnt_reg   <= '0;
      ones_reg  <= '0;
      zrun_reg  <= '0;
      los_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      ones_reg  <= ones_next;
      zrun_reg  <= zrun_next;
      los_reg   <= los_next;
    end
  end

  assign los_rise = los_next & ~los_reg;

  // ---------------------------------------------------------------
  // Alarm indication signal
  // ---------------------------------------------------------------
  logic [BW-1:0] bit_reg;
  logic [1:0]    zeros_reg;
  logic          agree_reg;
  wire           ais_on;
  wire           blk_end;
  wire  [1:0]    zeros_now;
  wire           verdict;

  assign ais_on    = ctrl_reg.cdr_enable & ~rx_pd;
  assign blk_end   = tick && bit_reg == BW'(BLOCK - 1);
  assign zeros_now = (!mark && zeros_reg != 2'(AIS_ZEROS)) ? zeros_reg + 1'b1
                   : zeros_reg;
  assign verdict   = zeros_now < 2'(AIS_ZEROS);

  always_ff @(posedge sys_clk)
  begin
    if (reset || !ais_on)
    begin
      bit_reg   <= '0;
      zeros_reg <= '0;
      agree_reg <= 1'b0;
      ais_reg   <= 1'b0;
    end
    else if (tick)
    begin
      bit_reg   <= blk_end ? '0 : bit_reg + 1'b1;
      zeros_reg <= blk_end ? 2'd0 : zeros_now;
      if (blk_end)
      begin
        if (verdict != ais_reg && (ctrl_reg.detect_criteria_select || agree_reg))
          ais_reg <= verdict;
        agree_reg <= verdict != ais_reg && !ctrl_reg.detect_criteria_select
                     && !agree_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Output stage and all-ones fill
  // ---------------------------------------------------------------
  logic       ones_tgl_reg;
  logic       los_pin_reg;
  logic [1:0] rail_reg;
  logic       rclk_out_reg;
  logic [1:0] tx_reg;
  wire        sys_fill;
  wire        line_fill;

  assign sys_fill  = los_reg & ctrl_reg.system_alarm_fill_enable;
  assign line_fill = los_reg & ctrl_reg.line_alarm_fill_enable;

  always_ff @(posedge sys_clk)
  begin
    if (reset || rx_pd)
    begin
      los_pin_reg  <= 1'b0;
      rail_reg     <= 2'b00;
      rclk_out_reg <= 1'b0;
      tx_reg       <= 2'b00;
      ones_tgl_reg <= 1'b0;
    end
    else
    begin
      ones_tgl_reg <= mtick ? ~ones_tgl_reg : ones_tgl_reg;
      // pin follows loss; low on clear
      los_pin_reg  <= los_reg;
      rail_reg     <= sys_fill ? {~ones_tgl_reg, ones_tgl_reg}
                               : {s.rail_neg, s.rail_pos};
      rclk_out_reg <= sys_fill ? s.mclk : s.rclk;
      tx_reg       <= line_fill ? {~ones_tgl_reg, ones_tgl_reg} : 2'b00;
    end
  end

  assign los_pin            = los_pin_reg;
  assign receive_rail_pair  = rail_reg;
  assign rx_clk_out         = rclk_out_reg;
  assign transmit_line_pair = tx_reg;
  assign line_fill_active   = line_fill & ~rx_pd;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_short_expiry;
    state_reg == ST_OK && los_active && tick && s.below_q
      && !ctrl_reg.detect_criteria_select && cnt_reg == CW'(N_S - 1);
  endsequence

  sequence s_clear_done;
    !los_next && los_reg && los_active;
  endsequence

  a_los_declare_short: assert property (s_short_expiry |=> los_reg ##1 los_pin)
    else $error("loss not declared after short window");
  a_los_pin_set: assert property ($rose(los_reg) && !rx_pd |=> los_pin)
    else $error("loss pin not raised");
  a_los_irq_set: assert property ($rose(los_reg) && !ctrl_reg.irq_mask ##1 !rx_pd |-> los_irq)
    else $error("loss interrupt missing");
  a_los_clear_win: assert property (s_clear_done |-> cnt_reg == CW'(M_CLEAR - 1))
    else $error("loss cleared outside window end");
  a_los_pin_clear: assert property ($fell(los_reg) |=> !los_pin)
    else $error("loss pin not lowered");
  a_hw_no_eq: assert property (s.hw_mode |-> !eq_active && threshold_code == 5'h00)
    else $error("equalizer active under pin control");
  a_crit_reset: assert property ($past(reset) |-> !ctrl_reg.detect_criteria_select)
    else $error("criteria select not cleared");
  a_sys_fill_clk: assert property (sys_fill && !rx_pd |=> rx_clk_out == $past(s.mclk))
    else $error("master clock not substituted");
  a_line_quiet: assert property (!line_fill |=> transmit_line_pair == 2'b00)
    else $error("line fill without loss");
  a_monitor_quiet: assert property (ctrl_reg.monitor_gain |=> !los_reg)
    else $error("loss shown under monitor gain");
  a_ais_needs_cdr: assert property (!ais_on |=> !ais_reg)
    else $error("alarm status without clock recovery");
  a_power_low: assert property (rx_pd |=> !los_pin && rx_clk_out == 1'b0 && receive_rail_pair == 2'b00)
    else $error("outputs not low in power down");
endmodule
`default_nettype wire

// ===== tb/eld_front_model.sv
/*
  Receive front-end model: recovered and master clocks, AMI rails, level flags.
  Assumes the bench drives mark_en and the level flags right after clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
module eld_front_model
  import eld_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          mark_en,
  input  wire logic          below_q,
  input  wire logic          above_p,
  input  wire logic          hw_mode,
  output eld_pkg::eld_pins_t pins
);
  import eld_pkg::*;
  logic [2:0] rcnt_reg = 3'h0;
  logic [3:0] mcnt_reg = 4'h0;
  logic       pol_reg  = 1'b0;
  logic [1:0] rail_reg = 2'h0;
  // ---------------------------------------------------------------
  // Clocks and rails
  // ---------------------------------------------------------------
  // Rails change mid-low so each rising edge samples settled data
  always_ff @(posedge sys_clk)
  begin
    rcnt_reg <= rcnt_reg + 3'h1;
    mcnt_reg <= (mcnt_reg == 4'h9) ? 4'h0 : mcnt_reg + 4'h1;
    if (rcnt_reg == 3'h1)
    begin
      rail_reg <= mark_en ? (pol_reg ? 2'h2 : 2'h1) : 2'h0;
      pol_reg  <= pol_reg ^ mark_en;
    end
  end
  assign pins = '{hw_mode: hw_mode, above_p: above_p, below_q: below_q, mclk: mcnt_reg > 4'h4,
                  rclk: rcnt_reg[2], rail_neg: rail_reg[1], rail_pos: rail_reg[0]};
endmodule
`default_nettype wire

// ===== tb/eld_detect_bench.sv
/*
  Self-checking bench of the loss and alarm detector.
  Assumes shortened long-loss and alarm-block counts passed as parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module eld_detect_bench;
  import eld_pkg::*;
  localparam int NL = 64;
  localparam int BL = 16;
  localparam int TK = 8;
  logic              sys_clk, reset, wr_stb, rd_stb, mark_en, below_q, above_p, hw_mode;
  logic [7:0]        addr;
  logic [31:0]       wr_data, rd_data, d;
  logic              los_pin, los_irq, rx_clk_out, line_fill_active, eq_active;
  logic [1:0]        receive_rail_pair, transmit_line_pair;
  logic [4:0]        threshold_code;
  eld_pins_t         pins;
  int                fails = 0;
  int                cmp_count = 0;
  eld_front_model eld_front_model_inst (.sys_clk(sys_clk), .mark_en(mark_en), .below_q(below_q),
    .above_p(above_p), .hw_mode(hw_mode), .pins(pins));
  eld_detect #(.N_L(NL), .BLOCK(BL)) eld_detect_inst (.sys_clk(sys_clk), .reset(reset), .pins(pins),
    .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .los_pin(los_pin), .los_irq(los_irq), .receive_rail_pair(receive_rail_pair), .rx_clk_out(rx_clk_out),
    .transmit_line_pair(transmit_line_pair), .line_fill_active(line_fill_active),
    .eq_active(eq_active), .threshold_code(threshold_code));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= v;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1;
    v = rd_data;
  endtask
  task automatic line(input logic m, input logic bq, input logic ap);
    @(posedge sys_clk);
    mark_en <= m;
    below_q <= bq;
    above_p <= ap;
  endtask
  task automatic wait_los(input logic v, input string name);
    for (int i = 0; i < 120 && los_pin !== v; i++) idle(1);
    chk(name, los_pin, v);
  endtask
  task automatic wait_ais(input logic v, input string name);
    for (int i = 0; i < 400 && d[ST_AIS_BIT] !== v; i++) rd(ADDR_STATUS, d);
    chk(name, d[ST_AIS_BIT], v);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(ADDR_CTRL, d);
    chk("ctrl_reset", d, 32'h0);
    rd(ADDR_STATUS, d);
    chk("status_reset", d, 32'h0);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, d);
    chk("unmapped_read", d, 32'h0);
    rd(ADDR_CTRL, d);
    chk("unmapped_write", d, 32'h0);
  endtask
  task automatic t_loss_short;
    wr(ADDR_CTRL, 32'h10);
    line(1'b0, 1'b1, 1'b0);
    idle(26 * TK);
    chk("los_early", los_pin, 1'b0);
    wait_los(1'b1, "los_declare");
    chk("irq_unmasked", los_irq, 1'b1);
    wr(ADDR_CTRL, 32'h96);
    idle(25);
    chk("irq_masked", los_irq, 1'b0);
    chk("line_fill", line_fill_active, 1'b1);
    chk("sys_ones", receive_rail_pair != 2'h0, 1'b1);
    chk("line_ones", transmit_line_pair != 2'h0, 1'b1);
    rd(ADDR_STATUS, d);
    chk("status_loss", d[2:0], 3'h5);
    wr(ADDR_STATUS, 32'h4);
    rd(ADDR_STATUS, d);
    chk("event_clear", d[2:0], 3'h1);
    line(1'b1, 1'b0, 1'b0);
    idle(40 * TK);
    chk("clear_needs_level", los_pin, 1'b1);
    line(1'b1, 1'b0, 1'b1);
    idle(26 * TK);
    chk("clear_early", los_pin, 1'b1);
    wait_los(1'b0, "los_clear");
    wr(ADDR_CTRL, 32'h10);
  endtask
  task automatic t_loss_long;
    wr(ADDR_CTRL, 32'h11);
    line(1'b0, 1'b1, 1'b0);
    idle(58 * TK);
    chk("long_early", los_pin, 1'b0);
    wait_los(1'b1, "long_declare");
    wr(ADDR_CTRL, 32'h31);
    idle(6);
    chk("pd_los", los_pin, 1'b0);
    chk("pd_clk", rx_clk_out, 1'b0);
    chk("pd_rails", receive_rail_pair, 2'h0);
    line(1'b1, 1'b0, 1'b1);
    wr(ADDR_CTRL, 32'h50);
    line(1'b0, 1'b1, 1'b0);
    idle(40 * TK);
    chk("monitor_gain", los_pin, 1'b0);
    line(1'b1, 1'b0, 1'b1);
    wr(ADDR_CTRL, 32'h10);
    idle(40 * TK);
    chk("rails_pass", receive_rail_pair != 2'h0, 1'b1);
  endtask
  task automatic t_alarm;
    wr(ADDR_CTRL, 32'h01);
    idle(4 * BL * TK);
    rd(ADDR_STATUS, d);
    chk("ais_no_cdr", d[ST_AIS_BIT], 1'b0);
    wr(ADDR_CTRL, 32'h11);
    wait_ais(1'b1, "ais_set_one");
    line(1'b0, 1'b0, 1'b1);
    wait_ais(1'b0, "ais_clear_one");
    wr(ADDR_CTRL, 32'h10);
    line(1'b1, 1'b0, 1'b1);
    idle(24 * TK);
    rd(ADDR_STATUS, d);
    chk("ais_two_blocks", d[ST_AIS_BIT], 1'b0);
    wait_ais(1'b1, "ais_set_two");
    line(1'b0, 1'b0, 1'b1);
    idle(24 * TK);
    rd(ADDR_STATUS, d);
    chk("ais_hold", d[ST_AIS_BIT], 1'b1);
    wait_ais(1'b0, "ais_clear_two");
    line(1'b1, 1'b0, 1'b1);
  endtask
  task automatic t_level;
    wr(ADDR_CTRL, 32'h0a18);
    idle(4);
    chk("eq_on", eq_active, 1'b1);
    chk("level_code", threshold_code, 5'h0a);
    @(posedge sys_clk);
    hw_mode <= 1'b1;
    idle(4);
    chk("hw_no_eq", eq_active, 1'b0);
    chk("hw_no_level", threshold_code, 5'h00);
    @(posedge sys_clk);
    hw_mode <= 1'b0;
    wr(ADDR_CTRL, 32'h0a10);
    idle(4);
    chk("fixed_level", threshold_code, 5'h00);
  endtask
  // ---------------------------------------------------------------
  // Clock, sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    reset = 1'b1;
    {wr_stb, rd_stb, below_q, hw_mode} = 4'h0;
    {mark_en, above_p} = 2'h3;
    addr = 8'h00;
    wr_data = 32'h0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_loss_short();
    t_loss_long();
    t_alarm();
    t_level();
    conclude();
  end
  initial
  begin
    #(25ns * 60000);
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
